// file: rtl/microstep_timer.sv
`timescale 1ns/1ps
module microstep_timer #(
    parameter int CNT_W = 21,
    parameter int LIMIT = 1048576
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           clk_en,
    input  wire logic                           start,
    input  wire logic                           enable,
    input  wire logic [stepdir_pkg::RES_W-1:0]  shift,
    output logic                                tick,
    output logic                                busy,
    output logic                                idle_full,
    output logic      [CNT_W-1:0]               period_q
);
    localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    if (LIMIT < 2 || LIMIT >= (1 << CNT_W))
    begin : g_check
        $error("idle limit does not fit the period counter");
    end

    logic [CNT_W-1:0] elapsed_q;
    logic [CNT_W-1:0] spacing_q;
    logic [CNT_W-1:0] gap_q;
    logic [7:0]       left_q;

    function automatic logic [CNT_W-1:0] spacing(input logic [CNT_W-1:0] p,
                                                 input logic [3:0] s);
        logic [CNT_W-1:0] v;
        v = p >> s;
        return (v == '0) ? ONE : v;
    endfunction

    assign busy      = left_q != 8'h00;
    assign idle_full = elapsed_q == LIM;
    assign tick      = clk_en && enable && busy && gap_q == ONE;

    // Saturating step period measurement; saturation doubles as idle detect.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            elapsed_q <= '0;
            period_q  <= '0;
        end
        else if (clk_en)
        begin
            if (start)
            begin
                period_q  <= elapsed_q;
                elapsed_q <= ONE;
            end
            else if (!idle_full)
            begin
                elapsed_q <= elapsed_q + ONE;
            end
        end
    end

    // A new step restarts the train; pending microsteps are dropped.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spacing_q <= ONE;
            gap_q     <= ONE;
            left_q    <= 8'h00;
        end
        else if (clk_en)
        begin
            if (start)
            begin
                spacing_q <= spacing(elapsed_q, shift);
                gap_q     <= spacing(elapsed_q, shift);
                left_q    <= enable ? 8'((9'h001 << shift) - 9'h001) : 8'h00;
            end
            else if (!enable)
            begin
                left_q <= 8'h00;
            end
            else if (busy)
            begin
                if (gap_q == ONE)
                begin
                    left_q <= left_q - 8'h01;
                    gap_q  <= spacing_q;
                end
                else
                begin
                    gap_q <= gap_q - ONE;
                end
            end
        end
    end

    property p_spacing;
        @(posedge pclk) disable iff (!presetn)
        clk_en && start |=> spacing_q == spacing($past(elapsed_q), $past(shift));
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("microstep spacing is not the last period divided");

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        clk_en && start && enable |=>
            left_q == 8'((9'h001 << $past(shift)) - 9'h001);
    endproperty
    a_restart: assert property (p_restart)
        else $error("new step did not restart the microstep train");

    property p_interp_off;
        @(posedge pclk) disable iff (!presetn)
        clk_en && !enable |=> !busy;
    endproperty
    a_interp_off: assert property (p_interp_off)
        else $error("microsteps pending while interpolation is off");
endmodule

// file: rtl/step_dir_microstep_interpolator.sv
// Contract
// - dedge set: both STEP edges count
// - synchronise STEP and DIR before use
// - counter indexes 1024-entry table, four full steps
// - DIR low adds width, high subtracts
// - width 1 finest, doubling to 256 full step
// - coarser resolution snaps to nearest valid position
// - full step visits 128, 384, 640, 896
// - half from 64 by 128, quarter 32 by 64
// - interpolation expands each step to width single microsteps (256 at full step)
// - interpolation only while intpol bit set
// - microsteps evenly spaced over previous period
// - no step for 2^20 cycles sets standstill
// - standstill selects hold current scale
// - next active step clears standstill
// - adapts after one period; pending microsteps abandoned
`timescale 1ns/1ps
module step_dir_microstep_interpolator #(
    parameter int IDLE_CYCLES = stepdir_pkg::IDLE_CYCLES
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              clk_en,
    input  wire logic                              step_in,
    input  wire logic                              dir_in,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [stepdir_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    output logic      [stepdir_pkg::POS_W-1:0]     table_index,
    output logic      [stepdir_pkg::SCALE_W-1:0]   current_scale,
    output logic                                   standstill,
    output logic                                   irq
);
    localparam int CNT_W = $clog2(IDLE_CYCLES + 1);
    localparam int POS_W = stepdir_pkg::POS_W;

    if (IDLE_CYCLES < 16 || CNT_W > 32 || (1 << POS_W) != stepdir_pkg::TABLE_ENTRIES)
    begin : g_check
        $error("idle limit too small or table size inconsistent");
    end

    // ------------------------------------------------------------------
    // Position arithmetic
    // ------------------------------------------------------------------
    function automatic logic [POS_W-1:0] width(input logic [3:0] res);
        return POS_W'(11'h001 << res);
    endfunction

    function automatic logic [POS_W-1:0] move(input logic [POS_W-1:0] pos,
                                              input logic dir,
                                              input logic [POS_W-1:0] w);
        // Plain ten-bit arithmetic wraps around the electrical revolution.
        return dir ? pos - w : pos + w;
    endfunction

    // Centre of the cell that holds pos, never a zero-current entry; at finest resolution pos is returned unchanged.
    function automatic logic [POS_W-1:0] snap(input logic [POS_W-1:0] pos,
                                              input logic [3:0] res);
        logic [POS_W-1:0] w;
        w = width(res);
        if (res == stepdir_pkg::RES_FINEST)
        begin
            return pos;
        end
        return (pos & ~(w - POS_W'(1))) | (w >> 1);
    endfunction

    // ------------------------------------------------------------------
    // Pin front end
    // ------------------------------------------------------------------
    logic [1:0] pins_s;
    logic       step_s;
    logic       dir_s;
    logic       step_prev_q;
    logic       step_rise;
    logic       step_fall;
    logic       step_event;

    sync_2ff #(
        .W       (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .d       ({dir_in, step_in}),
        .q       (pins_s)
    );

    assign step_s = pins_s[0];
    assign dir_s  = pins_s[1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            step_prev_q <= step_s;
        end
    end

    logic       dedge_q;
    assign step_rise  = step_s && !step_prev_q;
    assign step_fall  = !step_s && step_prev_q;
    assign step_event = clk_en && (step_rise || (dedge_q && step_fall));

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    logic                     intpol_q;
    logic [3:0]               res_q;
    logic [4:0]               hold_q;
    logic [4:0]               run_q;
    logic [stepdir_pkg::INT_W-1:0] int_stat_q;
    logic [stepdir_pkg::INT_W-1:0] int_mask_q;
    logic                     access;
    logic                     wr;
    logic                     mapped;
    logic                     wr_ctrl;
    logic [3:0]               new_res;
    logic                     regrid;

    assign access  = psel && penable && clk_en;
    assign wr      = access && pwrite;
    assign mapped  = paddr == stepdir_pkg::ADDR_CTRL || paddr == stepdir_pkg::ADDR_STATUS
                  || paddr == stepdir_pkg::ADDR_INT_STAT || paddr == stepdir_pkg::ADDR_INT_MASK
                  || paddr == stepdir_pkg::ADDR_PERIOD;
    assign wr_ctrl = wr && paddr == stepdir_pkg::ADDR_CTRL;
    assign new_res = pwdata[stepdir_pkg::CTRL_RES_LSB +: 4];
    // Resolutions beyond full step are refused; the field keeps its value.
    // A finer setting snaps as well, because a coarse position lies off the
    // finer grid and could otherwise walk onto a zero-current entry.
    assign regrid  = wr_ctrl && new_res <= stepdir_pkg::RES_FULL && new_res != res_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dedge_q  <= 1'b0;
            intpol_q <= 1'b0;
            res_q    <= stepdir_pkg::RES_FINEST;
            hold_q   <= stepdir_pkg::HOLD_RST;
            run_q    <= stepdir_pkg::RUN_RST;
        end
        else if (wr_ctrl)
        begin
            dedge_q  <= pwdata[stepdir_pkg::CTRL_DEDGE];
            intpol_q <= pwdata[stepdir_pkg::CTRL_INTPOL];
            hold_q   <= pwdata[stepdir_pkg::CTRL_HOLD_LSB +: 5];
            run_q    <= pwdata[stepdir_pkg::CTRL_RUN_LSB +: 5];
            if (new_res <= stepdir_pkg::RES_FULL)
            begin
                res_q <= new_res;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interpolator
    // ------------------------------------------------------------------
    logic             interp_on;
    logic             tick;
    logic             busy;
    logic             idle_full;
    logic [CNT_W-1:0] period;
    logic             idir_q;

    assign interp_on = intpol_q && res_q != stepdir_pkg::RES_FINEST;

    microstep_timer #(
        .CNT_W     (CNT_W),
        .LIMIT     (IDLE_CYCLES)
    ) u_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .start     (step_event),
        .enable    (interp_on),
        .shift     (res_q),
        .tick      (tick),
        .busy      (busy),
        .idle_full (idle_full),
        .period_q  (period)
    );

    // ------------------------------------------------------------------
    // Microstep counter
    // ------------------------------------------------------------------
    // The target is where the step input says the rotor belongs; the
    // counter trails it by the microsteps still to be issued.
    logic [POS_W-1:0] count_q;
    logic [POS_W-1:0] target_q;
    logic [POS_W-1:0] base_t;
    logic [POS_W-1:0] base_c;

    assign base_t = regrid ? snap(target_q, new_res) : target_q;
    assign base_c = regrid ? snap(count_q, new_res) : count_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q  <= '0;
            target_q <= '0;
            idir_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (step_event)
            begin
                target_q <= move(base_t, dir_s, width(regrid ? new_res : res_q));
                idir_q   <= dir_s;
                if (interp_on)
                begin
                    // Unissued microsteps are dropped: the counter jumps.
                    count_q <= move(base_t, dir_s, POS_W'(1));
                end
                else
                begin
                    count_q <= move(base_t, dir_s, width(regrid ? new_res : res_q));
                end
            end
            else
            begin
                target_q <= base_t;
                if (!interp_on)
                begin
                    count_q <= base_t;
                end
                else if (tick)
                begin
                    count_q <= move(base_c, idir_q, POS_W'(1));
                end
                else
                begin
                    count_q <= base_c;
                end
            end
        end
    end

    assign table_index = count_q;

    // ------------------------------------------------------------------
    // Standstill and current scale
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            standstill    <= 1'b0;
            current_scale <= stepdir_pkg::RUN_RST;
        end
        else if (clk_en)
        begin
            if (step_event)
            begin
                standstill <= 1'b0;
            end
            else if (idle_full)
            begin
                standstill <= 1'b1;
            end
            current_scale <= standstill ? hold_q : run_q;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts and register reads
    // ------------------------------------------------------------------
    logic [stepdir_pkg::INT_W-1:0] int_set;
    logic [31:0]                   rd_mux;

    assign int_set[stepdir_pkg::INT_STST] = clk_en && idle_full && !standstill && !step_event;
    assign int_set[stepdir_pkg::INT_STEP] = step_event;
    assign int_set[stepdir_pkg::INT_JUMP] = step_event && busy;

    // A new event outweighs a write-one-to-clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_stat_q <= '0;
            int_mask_q <= '0;
        end
        else
        begin
            if (wr && paddr == stepdir_pkg::ADDR_INT_MASK)
            begin
                int_mask_q <= pwdata[stepdir_pkg::INT_W-1:0];
            end
            if (wr && paddr == stepdir_pkg::ADDR_INT_STAT)
            begin
                int_stat_q <= (int_stat_q & ~pwdata[stepdir_pkg::INT_W-1:0]) | int_set;
            end
            else
            begin
                int_stat_q <= int_stat_q | int_set;
            end
        end
    end

    assign irq     = |(int_stat_q & int_mask_q);
    assign pready  = clk_en;
    assign pslverr = psel && penable && !mapped;

    always_comb
    begin
        rd_mux = '0;
        case (paddr)
            stepdir_pkg::ADDR_CTRL:
            begin
                rd_mux[stepdir_pkg::CTRL_DEDGE]          = dedge_q;
                rd_mux[stepdir_pkg::CTRL_INTPOL]         = intpol_q;
                rd_mux[stepdir_pkg::CTRL_RES_LSB +: 4]   = res_q;
                rd_mux[stepdir_pkg::CTRL_HOLD_LSB +: 5]  = hold_q;
                rd_mux[stepdir_pkg::CTRL_RUN_LSB +: 5]   = run_q;
            end
            stepdir_pkg::ADDR_STATUS:
            begin
                rd_mux[POS_W-1:0]                        = count_q;
                rd_mux[stepdir_pkg::STAT_DIR]            = dir_s;
                rd_mux[stepdir_pkg::STAT_STST]           = standstill;
                rd_mux[stepdir_pkg::STAT_SCALE +: 5]     = current_scale;
            end
            stepdir_pkg::ADDR_INT_STAT: rd_mux[stepdir_pkg::INT_W-1:0] = int_stat_q;
            stepdir_pkg::ADDR_INT_MASK: rd_mux[stepdir_pkg::INT_W-1:0] = int_mask_q;
            stepdir_pkg::ADDR_PERIOD:   rd_mux[CNT_W-1:0]              = period;
            default:                    rd_mux                         = '0;
        endcase
    end

    // Read data is captured in the setup cycle so the access needs no wait.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (clk_en && psel && !penable && !pwrite)
        begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_dir_step;
        @(posedge pclk) disable iff (!presetn)
        step_event && !interp_on && !regrid |=> count_q == ($past(dir_s)
            ? $past(target_q) - $past(width(res_q)) : $past(target_q) + $past(width(res_q)));
    endproperty
    a_dir_step: assert property (p_dir_step)
        else $error("step did not move the counter by the width");

    property p_single_edge;
        @(posedge pclk) disable iff (!presetn)
        clk_en && step_fall && !dedge_q && !regrid |=> $stable(target_q);
    endproperty
    a_single_edge: assert property (p_single_edge)
        else $error("falling step edge moved counter in single-edge mode");

    property p_fullstep;
        @(posedge pclk) disable iff (!presetn)
        res_q == stepdir_pkg::RES_FULL |-> target_q[7:0] == 8'h80;
    endproperty
    a_fullstep: assert property (p_fullstep)
        else $error("full step position off the 45 degree grid");

    property p_valid_pos;
        @(posedge pclk) disable iff (!presetn)
        res_q != stepdir_pkg::RES_FINEST && !intpol_q && $past(!intpol_q) |->
            count_q == snap(count_q, res_q);
    endproperty
    a_valid_pos: assert property (p_valid_pos)
        else $error("counter not on a valid position for the resolution");

    property p_stst_set;
        @(posedge pclk) disable iff (!presetn)
        clk_en && idle_full && !step_event |=> standstill;
    endproperty
    a_stst_set: assert property (p_stst_set)
        else $error("standstill not flagged after idle limit");

    property p_stst_clear;
        @(posedge pclk) disable iff (!presetn)
        step_event |=> !standstill ##1 (current_scale == $past(run_q) || !$past(clk_en));
    endproperty
    a_stst_clear: assert property (p_stst_clear)
        else $error("step did not clear standstill");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        clk_en && standstill |=> current_scale == $past(hold_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold current not applied in standstill");

    property p_tick_move;
        @(posedge pclk) disable iff (!presetn)
        tick && !step_event && !regrid |=>
            count_q == ($past(idir_q) ? $past(count_q) - POS_W'(1) : $past(count_q) + POS_W'(1));
    endproperty
    a_tick_move: assert property (p_tick_move)
        else $error("microstep did not move counter by one");
endmodule

// file: rtl/stepdir_pkg.sv
package stepdir_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          POS_W         = 10;
    localparam int          TABLE_ENTRIES = 1024;
    localparam int          RES_W         = 4;
    localparam int          SCALE_W       = 5;
    localparam int          INT_W         = 3;
    localparam int          ADDR_W        = 8;
    localparam logic [3:0]  RES_FINEST    = 4'h0;
    localparam logic [3:0]  RES_FULL      = 4'h8;
    localparam int          IDLE_CYCLES   = 1048576;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_INT_STAT = 8'h08;
    localparam logic [7:0]  ADDR_INT_MASK = 8'h0c;
    localparam logic [7:0]  ADDR_PERIOD   = 8'h10;

    localparam int          CTRL_DEDGE    = 0;
    localparam int          CTRL_INTPOL   = 1;
    localparam int          CTRL_RES_LSB  = 4;
    localparam int          CTRL_HOLD_LSB = 8;
    localparam int          CTRL_RUN_LSB  = 16;
    localparam int          STAT_DIR      = 12;
    localparam int          STAT_STST     = 16;
    localparam int          STAT_SCALE    = 24;

    localparam logic [4:0]  HOLD_RST      = 5'h08;
    localparam logic [4:0]  RUN_RST       = 5'h1f;

    localparam int          INT_STST      = 0;
    localparam int          INT_STEP      = 1;
    localparam int          INT_JUMP      = 2;

endpackage

// file: rtl/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else if (clk_en)
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

    property p_sync_delay;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) && $past(presetn, 2) && $past(clk_en) && $past(clk_en, 2) |->
            q == $past(d, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchroniser output is not the input two edges back");
endmodule

// file: sim/step_source.sv
`timescale 1ns/1ps
// ----------------------------------------
// Motion controller stand-in
// ----------------------------------------
module step_source (
    input  wire logic pclk,
    output logic      step_out,
    output logic      dir_out
);
    initial
    begin
        step_out = 1'b0;
        dir_out  = 1'b0;
    end
    // A four-cycle high and at least seven low cycles between pulses keep double-edge timing clean.
    task automatic pulse(input logic d);
        @(posedge pclk);
        dir_out <= d;
        repeat (2) @(posedge pclk);
        step_out <= 1'b1;
        repeat (4) @(posedge pclk);
        step_out <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// file: sim/tb_step_dir_microstep_interpolator.sv
`timescale 1ns/1ps
// ----------------------------------------
// Register and step sequence
// ----------------------------------------
module tb_step_dir_microstep_interpolator;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, rerr, standstill, irq, step_w, dir_w;
    logic [9:0]  table_index;
    logic [4:0]  current_scale;
    int          errors = 0;
    int          total_checks = 0;
    always #2 pclk = ~pclk;
    step_source step_source_i (.pclk(pclk), .step_out(step_w), .dir_out(dir_w));
    step_dir_microstep_interpolator #(.IDLE_CYCLES(64)) step_dir_microstep_interpolator_i (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .step_in(step_w), .dir_in(dir_w),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .table_index(table_index),
        .current_scale(current_scale), .standstill(standstill), .irq(irq));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the updates of the taking edge land before anything is compared.
        #1;
    endtask
    task automatic st(input logic d);
        step_source_i.pulse(d);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", rdata, 32'h001f0800);
        repeat (3) st(1'b0);
        check("index", table_index, 10'h003);
        st(1'b1);
        check("index", table_index, 10'h002);
        apb(1'b1, 8'h00, 32'h001f0801);
        st(1'b1);
        check("index", table_index, 10'h000);
        apb(1'b1, 8'h00, 32'h001f0800);
        st(1'b1);
        check("index", table_index, 10'h3ff);
        apb(1'b1, 8'h00, 32'h001f0860);
        check("index", table_index, 10'h3e0);
        apb(1'b1, 8'h00, 32'h001f0870);
        check("index", table_index, 10'h3c0);
        apb(1'b1, 8'h00, 32'h001f0880);
        check("index", table_index, 10'h380);
        st(1'b0);
        apb(1'b0, 8'h04, 32'h0);
        check("status", rdata[9:0], 10'h080);
        apb(1'b1, 8'h08, 32'h7);
        apb(1'b1, 8'h0c, 32'h1);
        repeat (80) @(posedge pclk);
        #1;
        check("standstill", standstill, 1'b1);
        check("scale", current_scale, 5'h08);
        check("irq", irq, 1'b1);
        apb(1'b1, 8'h08, 32'h1);
        check("irq", irq, 1'b0);
        st(1'b0);
        check("standstill", standstill, 1'b0);
        check("scale", current_scale, 5'h1f);
        apb(1'b0, 8'h14, 32'h0);
        check("slverr", rerr, 1'b1);
        check("unmapped", rdata, 32'h0);
        apb(1'b1, 8'h00, 32'h001f0882);
        st(1'b0);
        #1;
        check("index", table_index, 10'h186);
        st(1'b0);
        #1;
        check("index", table_index, 10'h286);
        apb(1'b0, 8'h10, 32'h0);
        check("period", rdata, 32'h0000000b);
        apb(1'b0, 8'h08, 32'h0);
        check("int_stat", rdata, 32'h00000006);
        apb(1'b1, 8'h00, 32'h001f0880);
        st(1'b0);
        check("index", table_index, 10'h080);
        conclude();
    end
    initial
    begin
        repeat (3000) @(posedge pclk);
        errors++;
        conclude();
    end
endmodule
